// >>> rtl/psram_cs_pkg.sv
// Purpose: shared widths, codes and states for the pseudo-SRAM select timing block
// Assumes: 10 MHz controller clock, timing settings held stable during an access
// Notes: half-cycle deselect gaps are rounded up to whole clocks
package psram_cs_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CODE_W = 4;
  localparam int MAXLEN_W = 9;
  localparam int LEN_W = 8;
  localparam int CNT_W = 10;
  localparam int LAT_W = 5;
  localparam int HIGH_W = 5;
  // codes 0..15 give 1..16 clocks; counter loaded with code runs code+1 cycles
  localparam logic [CNT_W-1:0] SETUP_HOLD_EXTRA = 10'h000;
  // 1.5 rounds up to 2 clocks: gap code c lasts c+2 clocks
  localparam logic [CNT_W-1:0] GAP_LOAD_EXTRA = 10'h001;
  localparam logic [CNT_W-1:0] GAP_TOTAL_EXTRA = 10'h002;
  localparam logic [LAT_W-1:0] LAT_BASE = 5'h05;
  localparam logic [CODE_W-1:0] LAT_CODE_MAX = 4'hb;
  localparam logic [HIGH_W-1:0] HIGH_SAT = 5'h1f;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SETUP  = 3'h1,
    ST_ACCESS = 3'h3,
    ST_HOLD   = 3'h2,
    ST_GAP    = 3'h6
  } cs_state_t;
endpackage

// >>> rtl/cycle_count_if.sv
`timescale 1ns/1ps
// Purpose: load/decrement control between the sequencer and a cycle counter
// Assumes: single clock domain
// Notes: zero is the counter's own combinational compare of its register
interface cycle_count_if #(parameter int W = 10);
  logic load;
  logic en;
  logic [W-1:0] load_val;
  logic [W-1:0] count;
  logic zero;
  modport ctrl (output load, output en, output load_val, input count, input zero);
  modport cnt (input load, input en, input load_val, output count, output zero);
endinterface

// >>> rtl/cycle_counter.sv
`timescale 1ns/1ps
// Purpose: loadable down counter for phase and low-time budgets
// Assumes: load has priority over decrement
// Notes: stops at zero so a missed reload cannot wrap into a long wait
module cycle_counter #(
  parameter int W = 10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  cycle_count_if.cnt cc
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (cc.load) begin
      count_next = cc.load_val;
    end else if (cc.en && count_reg != '0) begin
      count_next = count_reg - W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign cc.count = count_reg;
  assign cc.zero = (count_reg == '0);
endmodule

// >>> rtl/psram_cs_timing_ctrl.sv
`timescale 1ns/1ps
// Purpose: select setup/hold/gap, max low time and latency for the pseudo-SRAM space
// Assumes: settings stable from request acceptance until the gap ends
// Notes: a max low-time expiry releases select at once and skips the hold
module psram_cs_timing_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // timing settings
  input wire logic max_low_time_enable,
  input wire logic [psram_cs_pkg::MAXLEN_W-1:0] max_low_time_length,
  input wire logic [psram_cs_pkg::CODE_W-1:0] read_deselect_gap,
  input wire logic [psram_cs_pkg::CODE_W-1:0] write_deselect_gap,
  input wire logic [psram_cs_pkg::CODE_W-1:0] read_select_setup,
  input wire logic [psram_cs_pkg::CODE_W-1:0] write_select_setup,
  input wire logic [psram_cs_pkg::CODE_W-1:0] read_select_hold,
  input wire logic [psram_cs_pkg::CODE_W-1:0] write_select_hold,
  input wire logic [psram_cs_pkg::CODE_W-1:0] access_latency,
  // access request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [psram_cs_pkg::LEN_W-1:0] req_len,
  output logic req_ready,
  // memory side
  output logic psram_select_n,
  output logic access_active,
  output logic access_write,
  output logic [psram_cs_pkg::LAT_W-1:0] latency_clocks,
  output logic access_done,
  output logic access_cut
);
  import psram_cs_pkg::*;

  cycle_count_if #(.W(CNT_W)) phase_cc ();
  cycle_count_if #(.W(CNT_W)) low_cc ();

  cycle_counter #(.W(CNT_W)) phase_cnt (.clk(clk), .rst_b(rst_b), .cc(phase_cc));
  cycle_counter #(.W(CNT_W)) low_cnt (.clk(clk), .rst_b(rst_b), .cc(low_cc));

  cs_state_t state_reg, state_next;
  logic dir_reg, dir_next;
  logic [LEN_W-1:0] len_reg, len_next;
  logic sel_n_reg, sel_n_next;
  logic active_reg, active_next;
  logic ready_reg, ready_next;
  logic done_reg, done_next;
  logic cut_reg, cut_next;
  logic [LAT_W-1:0] lat_reg, lat_next;
  logic accept;
  logic expire;
  logic [CODE_W-1:0] setup_sel, hold_sel, gap_sel, lat_code;

  // read or write setting follows the direction latched at take
  always_comb begin
    setup_sel = dir_reg ? write_select_setup : read_select_setup;
    hold_sel = dir_reg ? write_select_hold : read_select_hold;
    gap_sel = dir_reg ? write_deselect_gap : read_deselect_gap;
    // out-of-range codes clamp to the longest latency rather than wrap
    lat_code = (access_latency > LAT_CODE_MAX) ? LAT_CODE_MAX : access_latency;
  end

  assign accept = req_valid && ready_reg;
  // low counter reaches zero on the (N+1)th low clock
  assign expire = max_low_time_enable && !sel_n_reg && low_cc.zero;

  always_comb begin
    state_next = state_reg;
    dir_next = dir_reg;
    len_next = len_reg;
    done_next = 1'b0;
    cut_next = 1'b0;
    phase_cc.load = 1'b0;
    phase_cc.en = 1'b1;
    phase_cc.load_val = '0;
    low_cc.load = accept;
    low_cc.en = !sel_n_reg;
    low_cc.load_val = CNT_W'(max_low_time_length);
    lat_next = LAT_BASE + LAT_W'(lat_code);
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          state_next = ST_SETUP;
          dir_next = req_write;
          len_next = req_len;
          phase_cc.load = 1'b1;
          phase_cc.load_val = CNT_W'(req_write ? write_select_setup : read_select_setup)
                              + SETUP_HOLD_EXTRA;
        end
      end
      ST_SETUP: begin
        if (phase_cc.zero) begin
          state_next = ST_ACCESS;
          phase_cc.load = 1'b1;
          phase_cc.load_val = CNT_W'(lat_reg) + CNT_W'(len_reg) - CNT_W'(1);
        end
      end
      ST_ACCESS: begin
        if (phase_cc.zero) begin
          state_next = ST_HOLD;
          done_next = 1'b1;
          phase_cc.load = 1'b1;
          phase_cc.load_val = CNT_W'(hold_sel) + SETUP_HOLD_EXTRA;
        end
      end
      ST_HOLD: begin
        if (phase_cc.zero) begin
          state_next = ST_GAP;
          phase_cc.load = 1'b1;
          phase_cc.load_val = CNT_W'(gap_sel) + GAP_LOAD_EXTRA;
        end
      end
      ST_GAP: begin
        if (phase_cc.zero) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // the limit overrides every low phase, the deselect gap still follows
    if (expire && state_reg != ST_GAP && state_reg != ST_IDLE) begin
      state_next = ST_GAP;
      cut_next = 1'b1;
      done_next = 1'b0;
      phase_cc.load = 1'b1;
      phase_cc.load_val = CNT_W'(gap_sel) + GAP_LOAD_EXTRA;
    end
    sel_n_next = !(state_next == ST_SETUP || state_next == ST_ACCESS ||
                   state_next == ST_HOLD);
    active_next = (state_next == ST_ACCESS);
    ready_next = (state_next == ST_IDLE);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      dir_reg <= 1'b0;
      len_reg <= '0;
      sel_n_reg <= 1'b1;
      active_reg <= 1'b0;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      cut_reg <= 1'b0;
      lat_reg <= LAT_BASE;
    end else begin
      state_reg <= state_next;
      dir_reg <= dir_next;
      len_reg <= len_next;
      sel_n_reg <= sel_n_next;
      active_reg <= active_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      cut_reg <= cut_next;
      lat_reg <= lat_next;
    end
  end

  assign req_ready = ready_reg;
  assign psram_select_n = sel_n_reg;
  assign access_active = active_reg;
  assign access_write = dir_reg;
  assign latency_clocks = lat_reg;
  assign access_done = done_reg;
  assign access_cut = cut_reg;

  // helper counters read only by the checks below
  logic [CNT_W-1:0] low_run_reg, low_run_next;
  logic [CNT_W-1:0] hold_run_reg, hold_run_next;
  logic [CNT_W-1:0] act_run_reg, act_run_next;
  logic [HIGH_W-1:0] high_run_reg, high_run_next;
  logic [CNT_W-1:0] gap_need_reg, gap_need_next;

  always_comb begin
    low_run_next = sel_n_reg ? '0 : low_run_reg + CNT_W'(1);
    hold_run_next = (active_reg || sel_n_reg) ? '0 : hold_run_reg + CNT_W'(1);
    act_run_next = active_reg ? act_run_reg + CNT_W'(1) : '0;
    high_run_next = !sel_n_reg ? '0 :
                    (high_run_reg == HIGH_SAT) ? high_run_reg : high_run_reg + HIGH_W'(1);
    gap_need_next = gap_need_reg;
    if (sel_n_next && !sel_n_reg) begin
      gap_need_next = CNT_W'(gap_sel) + GAP_TOTAL_EXTRA;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_run_reg <= '0;
      hold_run_reg <= '0;
      act_run_reg <= '0;
      high_run_reg <= '0;
      gap_need_reg <= '0;
    end else begin
      low_run_reg <= low_run_next;
      hold_run_reg <= hold_run_next;
      act_run_reg <= act_run_next;
      high_run_reg <= high_run_next;
      gap_need_reg <= gap_need_next;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence acc_taken;
    req_valid && req_ready;
  endsequence

  sequence acc_ended;
    $fell(access_active) && !access_cut;
  endsequence

  max_low_a: assert property (max_low_time_enable && !psram_select_n
    |-> low_run_reg <= CNT_W'(max_low_time_length))
    else $error("select held low past the max low time");
  setup_time_a: assert property ($rose(access_active)
    |-> low_run_reg == CNT_W'(setup_sel) + CNT_W'(1))
    else $error("access started after wrong setup time");
  hold_time_a: assert property ($rose(psram_select_n) && !access_cut
    |-> hold_run_reg == CNT_W'(hold_sel) + CNT_W'(1))
    else $error("select released after wrong hold time");
  deselect_gap_a: assert property ($fell(psram_select_n)
    |-> CNT_W'(high_run_reg) >= gap_need_reg)
    else $error("deselect gap too short");
  access_len_a: assert property (acc_ended
    |-> act_run_reg == CNT_W'(len_reg) + CNT_W'(latency_clocks))
    else $error("access phase length differs from latency plus length");
  latency_map_a: assert property (access_latency <= LAT_CODE_MAX
    |=> latency_clocks == LAT_BASE + LAT_W'($past(access_latency)))
    else $error("latency code mapped wrongly");
  direction_a: assert property (acc_taken
    |=> access_write == $past(req_write) && !psram_select_n)
    else $error("access direction not latched on acceptance");
  done_pulse_a: assert property (access_done
    |-> $past(access_active) && !access_active && !psram_select_n ##1 !access_done)
    else $error("done pulse not at end of access");
endmodule

// >>> testbench/psram_watch_model.sv
`timescale 1ns/1ps
// Purpose: far-side memory watcher, measures each select-low run on the wire
// Assumes: one clock, select sampled at rising edge like the memory would
// Notes: low_len updates only when select rises, so it always holds a whole run
module psram_watch_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // memory pins
  input wire logic psram_select_n,
  input wire logic access_active,
  // observations
  output logic [9:0] low_len,
  output logic stray
);
  logic [9:0] run_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      run_reg <= 10'h000;
      low_len <= 10'h000;
      stray <= 1'b0;
    end else begin
      // a deselected memory must never see an access phase
      if (access_active && psram_select_n) stray <= 1'b1;
      if (!psram_select_n) run_reg <= run_reg + 10'h001;
      else if (run_reg != 10'h000) begin
        low_len <= run_reg;
        run_reg <= 10'h000;
      end
    end
  end
endmodule

// >>> testbench/psram_cs_timing_ctrl_bench.sv
`timescale 1ns/1ps
// Purpose: self-checking bench for the pseudo-SRAM select timing block
// Assumes: inputs change at the falling clock edge
// Notes: phase lengths are counted in whole clocks at falling edges
module psram_cs_timing_ctrl_bench;
  import psram_cs_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic lim_en = 1'b0;
  logic [MAXLEN_W-1:0] lim_len = 9'h000;
  logic [CODE_W-1:0] rg = 4'h0, wg = 4'h5, rs = 4'h0, ws = 4'h3;
  logic [CODE_W-1:0] rh = 4'h0, wh = 4'h2, lat = 4'h0;
  logic req_valid = 1'b0, req_write = 1'b0;
  logic [LEN_W-1:0] req_len = 8'h00;
  logic req_ready, psram_select_n, access_active, access_write, access_done, access_cut, stray;
  logic [LAT_W-1:0] latency_clocks;
  logic [9:0] low_len;
  int error_cnt = 0, samples_checked = 0;

  always #50 clk = ~clk;

  psram_cs_timing_ctrl psram_cs_timing_ctrl_i (.clk(clk), .rst_b(rst_b),
    .max_low_time_enable(lim_en), .max_low_time_length(lim_len),
    .read_deselect_gap(rg), .write_deselect_gap(wg), .read_select_setup(rs),
    .write_select_setup(ws), .read_select_hold(rh), .write_select_hold(wh),
    .access_latency(lat), .req_valid(req_valid), .req_write(req_write),
    .req_len(req_len), .req_ready(req_ready), .psram_select_n(psram_select_n),
    .access_active(access_active), .access_write(access_write),
    .latency_clocks(latency_clocks), .access_done(access_done), .access_cut(access_cut));

  psram_watch_model psram_watch_model_i (.clk(clk), .rst_b(rst_b),
    .psram_select_n(psram_select_n), .access_active(access_active),
    .low_len(low_len), .stray(stray));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one access from take until ready returns; expected values from the codes
  task automatic run_chk(input string nm, input logic wr, input logic [7:0] len,
                         input int e_low, input int e_act, input int e_high, input logic e_done);
    int act, high, done, cut, n;
    logic seen;
    act = 0;
    high = 0;
    done = 0;
    cut = 0;
    seen = 1'b0;
    @(negedge clk);
    for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(negedge clk);
    chk(req_ready, 1'b1);
    req_write = wr;
    req_len = len;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    for (n = 0; n < 200 && req_ready !== 1'b1; n++) begin
      act += (access_active === 1'b1);
      done += (access_done === 1'b1);
      cut += (access_cut === 1'b1);
      if (psram_select_n === 1'b0) seen = 1'b1;
      else if (seen) high++;
      @(negedge clk);
    end
    // a wait that ran out shows up here as a mismatch
    chk(req_ready, 1'b1);
    chk(low_len, e_low);
    chk(act, e_act);
    chk(high, e_high);
    chk(done, e_done);
    chk(cut, !e_done);
    chk(access_write, wr);
    chk(stray, 0);
    $display("test %s finished", nm);
  endtask

  task automatic t_lat;
    for (int c = 0; c < 16; c++) begin
      lat = c[3:0];
      @(negedge clk);
      @(negedge clk);
      chk(latency_clocks, (c > 11) ? 16 : 5 + c);
    end
    lat = 4'h0;
    $display("test latency finished");
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    run_chk("walk", 1'b0, 8'h02, 9, 7, 2, 1'b1);
    lat = 4'hb;
    run_chk("write", 1'b1, 8'h00, 23, 16, 7, 1'b1);
    lat = 4'h0;
    rs = 4'hf;
    lim_len = 9'h003;
    lim_en = 1'b1;
    run_chk("cut", 1'b0, 8'h00, 4, 0, 2, 1'b0);
    lim_len = 9'h000;
    run_chk("cut_min", 1'b0, 8'h00, 1, 0, 2, 1'b0);
    lim_en = 1'b0;
    run_chk("no_limit", 1'b0, 8'h00, 22, 5, 2, 1'b1);
    t_lat();
    tally_and_finish();
  end

  // all tests need well under a thousand clocks
  initial begin
    #(100 * 20000);
    error_cnt++;
    tally_and_finish();
  end
endmodule
